// ---- hdl/cycle_timer.v ----
// down-counter that raises done when a loaded count has elapsed
// assumes load is a one-cycle pulse from the same clock
module cycle_timer #(
   parameter WIDTH = 16
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // control
   input  wire             load,
   input  wire [WIDTH-1:0] count,
   // status
   output wire             done
);
   reg [WIDTH-1:0] remaining;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         remaining <= {WIDTH{1'b0}};
      end else if (load) begin
         remaining <= count;
      end else if (remaining != {WIDTH{1'b0}}) begin
         remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign done = (remaining == {WIDTH{1'b0}}) && !load;
endmodule // cycle_timer

// ---- hdl/dpram_host_defs.vh ----
// timing figures and derived cycle counts for the dual-port memory port controller
// assumes a 40 MHz system clock; times in ns unless marked
`ifndef DPRAM_HOST_DEFS_VH
`define DPRAM_HOST_DEFS_VH
`define CLK_PERIOD_NS            25
`define CLK_FREQ_HZ              40000000
// slowest speed grade figures
`define SELECT_ACCESS_TIME_NS    90
`define OUTPUT_DRIVE_ACCESS_NS   40
`define OUTPUT_HOLD_TIME_NS      10
`define SELECT_TO_WRITE_END_NS   85
`define ADDRESS_TO_WRITE_END_NS  85
`define DATA_TO_WRITE_END_NS     40
`define WRITE_TO_OUTPUT_FLOAT_NS 40
`define BUSY_ASSERT_NS           45
`define ARBITRATION_SETUP_NS     5
`define DESELECT_TO_STANDBY_NS   50
`define POWER_UP_DELAY_US        500
// least times round up
`define READ_CYCLES    ((`SELECT_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES   ((`SELECT_TO_WRITE_END_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_CYCLES    ((`BUSY_ASSERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STANDBY_CYCLES ((`DESELECT_TO_STANDBY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_UP_CYCLES (`POWER_UP_DELAY_US * (`CLK_FREQ_HZ / 1000000))
// mailbox locations
`define MAILBOX_LEFT   10'h3FE
`define MAILBOX_RIGHT  10'h3FF
`define ADDR_WIDTH     10
`define DATA_WIDTH     8
`endif

// ---- hdl/dpram_port_host.v ----
// host controller for one port of an asynchronous 1K x 8 dual-port memory
// assumes the memory pins are asynchronous; busy and mailbox flags are synchronised here
//
// Summary of operation
// - arbitration is left to the memory; the host only retries a write that saw busy.
// - host holds each read select at least the select access time.
// - host keeps select low at least the minimum before write end.
// - host keeps address stable the minimum before and through write end.
// - host drives write data the minimum before strobe end, held to it.
// - host waits the power-up delay before its first access.
`include "dpram_host_defs.vh"
module dpram_port_host #(
   parameter POWER_UP_CYCLES = `POWER_UP_CYCLES,
   parameter RETRY_LIMIT     = 8
) (
   // clock and reset
   input  wire                     clk,
   input  wire                     reset_n,
   // user request
   input  wire                     reqValid,
   input  wire                     reqWrite,
   input  wire [`ADDR_WIDTH-1:0]   reqAddr,
   input  wire [`DATA_WIDTH-1:0]   reqData,
   output wire                     reqReady,
   // user answer
   output reg                      respValid,
   output reg  [`DATA_WIDTH-1:0]   respData,
   output reg                      respError,
   output reg                      mailboxPending,
   // memory port pins
   output reg                      chipSelect_n,
   output reg                      readWrite,
   output reg                      outputEnable_n,
   output reg  [`ADDR_WIDTH-1:0]   memAddr,
   output reg  [`DATA_WIDTH-1:0]   memDataOut,
   output reg                      memDataOe,
   input  wire [`DATA_WIDTH-1:0]   memDataIn,
   input  wire                     busy_n,
   input  wire                     mailbox_n
);
   localparam [2:0] ST_POWERUP = 3'h0;
   localparam [2:0] ST_IDLE    = 3'h1;
   localparam [2:0] ST_READ    = 3'h2;
   localparam [2:0] ST_WRITE   = 3'h3;
   localparam [2:0] ST_END     = 3'h4;
   localparam [2:0] ST_RECOVER = 3'h5;
   localparam       TW = 20;
   // integer figures, sliced to the timer width below
   localparam          READ_LEN    = `READ_CYCLES;
   localparam          WRITE_LEN   = `WRITE_CYCLES;
   localparam          BUSY_LEN    = `BUSY_CYCLES;
   localparam          STANDBY_LEN = `STANDBY_CYCLES;
   localparam [TW-1:0] READ_CNT    = READ_LEN[TW-1:0];
   localparam [TW-1:0] WRITE_CNT   = WRITE_LEN[TW-1:0];
   localparam [TW-1:0] BUSY_CNT    = BUSY_LEN[TW-1:0];
   localparam [TW-1:0] STANDBY_CNT = STANDBY_LEN[TW-1:0];
   localparam [TW-1:0] PU_CNT      = POWER_UP_CYCLES[TW-1:0];
   localparam [3:0]    RETRY_MAX   = RETRY_LIMIT[3:0];

   reg  [2:0]  state;
   reg         busySync1;
   reg         busySync2;
   reg         mailSync1;
   reg         mailSync2;
   reg         busySeen;
   reg  [3:0]  retries;
   reg         timerLoad;
   reg  [TW-1:0] timerCount;
   wire        timerDone;

   cycle_timer #(.WIDTH(TW)) timer (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (timerLoad),
      .count   (timerCount),
      .done    (timerDone)
   );

   // two-flop synchronisers for asynchronous flags
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busySync1 <= 1'b1;
         busySync2 <= 1'b1;
         mailSync1 <= 1'b1;
         mailSync2 <= 1'b1;
      end else begin
         busySync1 <= busy_n;
         busySync2 <= busySync1;
         mailSync1 <= mailbox_n;
         mailSync2 <= mailSync1;
      end
   end

   assign reqReady = (state == ST_IDLE);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state          <= ST_POWERUP;
         chipSelect_n   <= 1'b1;
         readWrite      <= 1'b1;
         outputEnable_n <= 1'b1;
         memAddr        <= {`ADDR_WIDTH{1'b0}};
         memDataOut     <= {`DATA_WIDTH{1'b0}};
         memDataOe      <= 1'b0;
         respValid      <= 1'b0;
         respData       <= {`DATA_WIDTH{1'b0}};
         respError      <= 1'b0;
         mailboxPending <= 1'b0;
         busySeen       <= 1'b0;
         retries        <= 4'h0;
         timerLoad      <= 1'b1;
         timerCount     <= {TW{1'b0}};
      end else begin
         timerLoad      <= 1'b0;
         respValid      <= 1'b0;
         mailboxPending <= !mailSync2;
         case (state)
            ST_POWERUP: begin
               if (timerCount == {TW{1'b0}}) begin
                  timerLoad  <= 1'b1;
                  timerCount <= PU_CNT;
               end else if (timerDone && !timerLoad) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (reqValid) begin
                  memAddr      <= reqAddr;
                  chipSelect_n <= 1'b0;
                  readWrite    <= !reqWrite;
                  busySeen     <= 1'b0;
                  retries      <= 4'h0;
                  // error of an earlier write must not block this one's retries
                  respError    <= 1'b0;
                  timerLoad    <= 1'b1;
                  if (reqWrite) begin
                     memDataOut <= reqData;
                     timerCount <= WRITE_CNT;
                     state      <= ST_WRITE;
                  end else begin
                     outputEnable_n <= 1'b0;
                     timerCount     <= READ_CNT;
                     state          <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               // busy does not block reads
               if (timerDone) begin
                  respData       <= memDataIn;
                  respValid      <= 1'b1;
                  respError      <= 1'b0;
                  chipSelect_n   <= 1'b1;
                  outputEnable_n <= 1'b1;
                  timerLoad      <= 1'b1;
                  timerCount     <= STANDBY_CNT;
                  state          <= ST_RECOVER;
               end
            end
            ST_WRITE: begin
               // data driven from the second write-state cycle, one clock (25 ns) after the strobe falls
               memDataOe <= 1'b1;
               if (timerCount == WRITE_CNT && !timerDone && !busySync2) begin
                  busySeen <= 1'b1;
               end
               if (timerDone) begin
                  // strobe and select rise together, data held through the edge
                  chipSelect_n <= 1'b1;
                  readWrite    <= 1'b1;
                  busySeen     <= busySeen || !busySync2;
                  state        <= ST_END;
               end
            end
            ST_END: begin
               memDataOe  <= 1'b0;
               timerLoad  <= 1'b1;
               timerCount <= STANDBY_CNT + BUSY_CNT;
               if (busySeen && retries != RETRY_MAX) begin
                  retries <= retries + 4'h1;
               end else begin
                  respValid <= 1'b1;
                  respError <= busySeen;
               end
               state <= ST_RECOVER;
            end
            ST_RECOVER: begin
               if (timerDone) begin
                  if (busySeen && retries != 4'h0 && !respError && !respValid) begin
                     // winner finished; repeat the suppressed write
                     if (busySync2) begin
                        chipSelect_n <= 1'b0;
                        readWrite    <= 1'b0;
                        busySeen     <= 1'b0;
                        timerLoad    <= 1'b1;
                        timerCount   <= WRITE_CNT;
                        state        <= ST_WRITE;
                     end
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // dpram_port_host

// ---- verification/dpram_model.sv ----
// behavioural dual-port memory as seen from its left port
// assumes the far port is reduced to a select, an address and a mailbox write
module dpram_model (
   // near port pins
   input  wire       clk,
   input  wire       chipSelect_n,
   input  wire       readWrite,
   input  wire       outputEnable_n,
   input  wire [9:0] memAddr,
   input  wire [7:0] memDataOut,
   input  wire       memDataOe,
   output wire [7:0] memDataIn,
   output wire       busy_n,
   output reg        mailbox_n,
   // far port
   input  wire       farSel,
   input  wire [9:0] farAddr,
   input  wire       farMbxWrite
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [7:0] mem [0:1023];
   reg       farFirst = 1'b0;
   wire      rdDrive = !chipSelect_n && readWrite && !outputEnable_n;
   initial mailbox_n = 1'b1;
   // far side wins when selected before us
   always @(negedge chipSelect_n) farFirst = farSel;
   assign #5 busy_n = !(farFirst && farSel && !chipSelect_n && farAddr == memAddr);
   // reads drive even while busy; floating pins show inverted data
   assign #60 memDataIn = rdDrive ? mem[memAddr] : ~mem[memAddr];
   always @(posedge clk) begin
      if (!chipSelect_n && !readWrite && memDataOe && busy_n)
         mem[memAddr] <= memDataOut;
      if (farMbxWrite)
         mailbox_n <= 1'b0;
      else if (rdDrive && memAddr == 10'h3FE)
         mailbox_n <= 1'b1;
   end
endmodule // dpram_model

// ---- verification/dpram_port_host_checker.sv ----
// pin-level timing checks for one memory-port host
// assumes it is bound into dpram_port_host and clocked by its clk
module dpram_port_host_checker #(parameter POWER_UP_CYCLES = 10) (
   // clock and reset
   input wire       clk,
   input wire       reset_n,
   // user side and memory pins
   input wire       reqReady,
   input wire       respValid,
   input wire       chipSelect_n,
   input wire       readWrite,
   input wire       outputEnable_n,
   input wire [9:0] memAddr,
   input wire       memDataOe
);
   reg [15:0] upCnt;
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
         upCnt <= 16'h0000;
      else if (upCnt != 16'hFFFF)
         upCnt <= upCnt + 16'h0001;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence readStart; $fell(chipSelect_n) && readWrite; endsequence
   sequence writeStart; $fell(chipSelect_n) && !readWrite; endsequence
   sequence selEnd; $rose(chipSelect_n); endsequence
   a_power_up_wait: assert property (upCnt < POWER_UP_CYCLES |-> chipSelect_n && !reqReady)
      else $error("access before power-up wait");
   a_read_select_long: assert property (readStart |-> !chipSelect_n [*4])
      else $error("read select too short");
   a_write_addr_hold: assert property (writeStart |=> (!chipSelect_n && $stable(memAddr)) [*3])
      else $error("write select or address not held");
   a_write_data_setup: assert property (selEnd and !$past(readWrite) |-> $past(memDataOe, 2))
      else $error("write data driven too late");
   a_no_drive_fight: assert property (memDataOe |-> outputEnable_n)
      else $error("data driven while output enabled");
   a_oe_read_only: assert property (!outputEnable_n |-> readWrite && !chipSelect_n)
      else $error("output enable outside a read");
   a_float_at_end: assert property (selEnd and $rose(readWrite) |-> outputEnable_n [*2])
      else $error("output enabled at write end");
   a_standby_gap: assert property (selEnd |-> chipSelect_n [*3])
      else $error("reselected too early");
   a_ready_idle: assert property (reqReady |-> chipSelect_n && !memDataOe)
      else $error("ready while port busy");
   a_resp_after_sel: assert property (respValid |-> chipSelect_n)
      else $error("answer before select released");
endmodule // dpram_port_host_checker

bind dpram_port_host dpram_port_host_checker #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) chk (
   .clk(clk), .reset_n(reset_n), .reqReady(reqReady), .respValid(respValid),
   .chipSelect_n(chipSelect_n), .readWrite(readWrite), .outputEnable_n(outputEnable_n),
   .memAddr(memAddr), .memDataOe(memDataOe));

// ---- verification/tb.sv ----
// self-checking bench for one memory-port host
// assumes a 40 MHz clock and a shortened power-up wait
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam PWR = 10;
   reg        clk = 1'b0;
   reg        reset_n = 1'b0;
   reg        reqValid = 1'b0;
   reg        reqWrite = 1'b0;
   reg  [9:0] reqAddr = 10'h000;
   reg  [7:0] reqData = 8'h00;
   reg        farSel = 1'b0;
   reg  [9:0] farAddr = 10'h000;
   reg        farMbxWrite = 1'b0;
   reg        expErr = 1'b0;
   wire       reqReady, respValid, respError, mailboxPending, busy_n, mailbox_n;
   wire       chipSelect_n, readWrite, outputEnable_n, memDataOe;
   wire [9:0] memAddr;
   wire [7:0] respData, memDataOut, memDataIn;
   int        n_mismatch = 0;
   int        compares = 0;
   time       tDone;
   always #12.5 clk = ~clk;
   dpram_port_host #(.POWER_UP_CYCLES(PWR)) DUT (.clk, .reset_n, .reqValid, .reqWrite,
      .reqAddr, .reqData, .reqReady, .respValid, .respData, .respError, .mailboxPending,
      .chipSelect_n, .readWrite, .outputEnable_n, .memAddr, .memDataOut, .memDataOe,
      .memDataIn, .busy_n, .mailbox_n);
   dpram_model partner (.clk, .chipSelect_n, .readWrite, .outputEnable_n, .memAddr,
      .memDataOut, .memDataOe, .memDataIn, .busy_n, .mailbox_n, .farSel, .farAddr,
      .farMbxWrite);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d);
      int i;
      i = 0;
      while (reqReady !== 1'b1 && i < 1000) begin
         @(negedge clk);
         i++;
      end
      @(posedge clk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqData <= d;
      @(posedge clk);
      reqValid <= 1'b0;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (respValid !== 1'b1 && i < 1000);
      tDone = $time;
      check({respValid, respError}, {6'h00, 1'b1, expErr});
   endtask
   task automatic t_power_up;
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check({7'h00, n >= PWR}, 8'h01);
      check({7'h00, mailboxPending}, 8'h00);
   endtask
   task automatic t_write_read;
      logic [9:0] ad [4] = '{10'h000, 10'h155, 10'h2AA, 10'h3FD};
      foreach (ad[k])
         access(1'b1, ad[k], ad[k][7:0] ^ 8'hA5);
      foreach (ad[k]) begin
         access(1'b0, ad[k], 8'h00);
         check(respData, ad[k][7:0] ^ 8'hA5);
      end
   endtask
   task automatic t_contention;
      time tFree;
      @(posedge clk);
      farAddr <= 10'h155;
      farSel <= 1'b1;
      access(1'b0, 10'h155, 8'h00);
      check(respData, 8'hF0);
      fork
         access(1'b1, 10'h155, 8'h3C);
         begin
            repeat (20) @(posedge clk);
            farSel <= 1'b0;
            tFree = $time;
         end
      join
      check({7'h00, tDone > tFree}, 8'h01);
      access(1'b0, 10'h155, 8'h00);
      check(respData, 8'h3C);
   endtask
   // far port holds the location through every retry: host gives up with an error
   task automatic t_give_up;
      @(posedge clk);
      farAddr <= 10'h2AA;
      farSel <= 1'b1;
      expErr <= 1'b1;
      access(1'b1, 10'h2AA, 8'h66);
      @(posedge clk);
      farSel <= 1'b0;
      expErr <= 1'b0;
      access(1'b0, 10'h2AA, 8'h00);
      check(respData, 8'h0F);
      access(1'b1, 10'h2AA, 8'h66);
      access(1'b0, 10'h2AA, 8'h00);
      check(respData, 8'h66);
   endtask
   task automatic t_mailbox;
      @(posedge clk);
      farMbxWrite <= 1'b1;
      @(posedge clk);
      farMbxWrite <= 1'b0;
      repeat (5) @(negedge clk);
      check({7'h00, mailboxPending}, 8'h01);
      access(1'b0, 10'h3FE, 8'h00);
      repeat (5) @(negedge clk);
      check({7'h00, mailboxPending}, 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_power_up;
      t_write_read;
      t_contention;
      t_give_up;
      t_mailbox;
      stop_test;
   end
   initial begin
      #200000;
      n_mismatch++;
      stop_test;
   end
endmodule // tb
